// >>> inc/aspbg_pkg.sv
package aspbg_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_TCTRL = 8'h08;
	localparam logic [7:0] ADDR_RELOAD = 8'h0C;
	localparam logic [7:0] ADDR_LOW = 8'h10;

	// serial_control_reg field positions
	localparam int CTRL_MODE = 7;
	localparam int CTRL_FILT = 5;
	localparam int CTRL_RXEN = 4;
	localparam int CTRL_TX9 = 3;
	localparam int CTRL_RX9 = 2;
	localparam int CTRL_TXD = 1;
	localparam int CTRL_RXD = 0;
	localparam logic CTRL_BIT6_VAL = 1'b1;

	// timer control field positions
	localparam int TCTRL_RUN = 0;
	localparam int TCTRL_SEL = 1;
	localparam int TCTRL_IEN = 4;

	// timer clock sources
	localparam logic [2:0] SRC_SYS = 3'h0;
	localparam logic [2:0] SRC_DIV12 = 3'h1;
	localparam logic [2:0] SRC_DIV148 = 3'h2;
	localparam logic [2:0] SRC_OSC8 = 3'h3;
	localparam logic [2:0] SRC_EXT = 3'h4;

	// prescaler terminal counts (divide by N means count 0..N-1)
	localparam logic [7:0] PRE_DIV12 = 8'h0B;
	localparam logic [7:0] PRE_DIV148 = 8'h93;
	localparam logic [7:0] PRE_OSC8 = 8'h07;

	localparam logic [7:0] TMR_TOP = 8'hFF;
	localparam logic [3:0] FRAME8_BITS = 4'hA;
	localparam logic [3:0] FRAME9_BITS = 4'hB;
	localparam logic [3:0] DATA8_LAST = 4'h7;
	localparam logic [3:0] DATA9_LAST = 4'h8;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} aspbg_rx_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} aspbg_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} aspbg_ahb_rsp_t;

	typedef struct packed {
		logic serialRxPin;
		logic extOscClk;
		logic rateTimerExtInput;
	} aspbg_pins_t;

	typedef struct packed {
		logic mode;
		logic filt;
		logic rxEn;
		logic txNinth;
		logic rxNinth;
		logic txDone;
		logic rxDone;
		logic [7:0] rxBuf;
		logic tmrRun;
		logic [2:0] tmrSel;
		logic intEn;
		logic [7:0] reload;
		logic [7:0] lowCnt;
		logic [7:0] rxTmr;
		logic [7:0] preCnt;
		logic [2:0] rxSync;
		logic [2:0] oscSync;
		logic [2:0] extSync;
		logic txHalf;
		logic rxHalf;
		logic [10:0] txShift;
		logic [3:0] txCnt;
		logic txPin;
		aspbg_rx_t rxState;
		logic [3:0] rxCnt;
		logic [8:0] rxShift;
		logic apValid;
		logic apWrite;
		logic [7:0] apAddr;
		logic [31:0] hrdata;
	} aspbg_state_t;

	localparam aspbg_state_t ST_RST = '{txPin: 1'b1, rxSync: 3'h7, rxState: RX_IDLE,
		default: '0};

endpackage

// >>> verilog/aspbg_serial_port.sv
// Function
// - bit clock comes from 8-bit auto-reload timer; low count byte clocks transmit.
// - hidden receive timer counts while timer runs, reloads from same reload byte.
// - transmit and receive timer overflows are halved to give bit rates.
// - a start edge on the receive pin forces a receive timer reload.
// - overflow rate is input clock over (256 - reload); bit rate is half.
// - timer clock is sysclk, sysclk/12, sysclk/148, oscillator/8 or external input.
// - frame mode bit, control bit 7, selects 8-bit or 9-bit frames.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// - 8-bit mode: data to receive buffer, stop bit to received ninth bit.
// - writing the data buffer starts a transmit frame when no frame is in progress.
// - transmit done flag sets at start of the stop bit, both modes.
// - frames are accepted only while receive enable is set.
// - 8-bit load only if receive done clear and, when filtering, stop bit high.
// - on overrun the first byte stays in the buffer; later bits are lost.
// - interrupt raised when enabled and transmit or receive done is set.
// - 9-bit frame: start, 8 data LSB first, ninth bit, stop; eleven bits.
// - 9-bit mode transmits the last written transmit ninth bit.
// - 9-bit mode stores received ninth bit, ignores the stop bit.
// - 9-bit load only if receive done clear and, when filtering, ninth bit high.
// - done flags are cleared only by a software write, never by servicing.
// - data buffer reads give receive byte; writes go to unreadable transmit register.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module aspbg_serial_port (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register bus
	input wire aspbg_pkg::aspbg_ahb_req_t ahbReq,
	output var aspbg_pkg::aspbg_ahb_rsp_t ahbRsp,
	// serial link and timer inputs
	input wire aspbg_pkg::aspbg_pins_t pinsIn,
	output var logic serialTxPin,
	// interrupt
	output var logic serialIrq
);
	import aspbg_pkg::*;

	aspbg_state_t s_r;
	aspbg_state_t s_nxt;

	logic oscRise, extRise, rxLine, rxFall;
	logic preEvt, preWrap, tmrTick, txOvf, rxOvf, txBitTick, rxSample;
	logic apTake, dpWrite, wrCtrl, wrData, wrTctrl, wrReload, wrLow;
	logic startDet, txStart, rxGate, rxLoad, txDoneSet;
	logic [3:0] rxLast;

	function automatic logic [7:0] preTopOf(input logic [2:0] sel);
		logic [7:0] top;
		top = 8'h00;
		if (sel == SRC_DIV12) begin
			top = PRE_DIV12;
		end else if (sel == SRC_DIV148) begin
			top = PRE_DIV148;
		end else if (sel == SRC_OSC8) begin
			top = PRE_OSC8;
		end
		return top;
	endfunction

	// auto reload from reload byte gives 256 - reload ticks per overflow
	function automatic logic [7:0] tmrNext(input logic [7:0] cnt, input logic [7:0] rld,
		input logic tick);
		logic [7:0] nxt;
		nxt = cnt;
		if (tick) begin
			nxt = (cnt == TMR_TOP) ? rld : 8'(cnt + 8'h01);
		end
		return nxt;
	endfunction

	// pin synchronisers: stage 0 feeds stage 1 only; stage 2 is for edges
	assign rxLine = s_r.rxSync[1];
	assign rxFall = ~s_r.rxSync[1] & s_r.rxSync[2];
	assign oscRise = s_r.oscSync[1] & ~s_r.oscSync[2];
	assign extRise = s_r.extSync[1] & ~s_r.extSync[2];

	// clock source choice; codes above 4 leave the timer stopped
	assign preEvt = (s_r.tmrSel == SRC_OSC8) ? oscRise : 1'b1;
	assign preWrap = preEvt && (s_r.preCnt == preTopOf(s_r.tmrSel));
	assign tmrTick = s_r.tmrRun && ((s_r.tmrSel == SRC_SYS)
		|| (s_r.tmrSel == SRC_EXT && extRise)
		|| ((s_r.tmrSel == SRC_DIV12 || s_r.tmrSel == SRC_DIV148
		|| s_r.tmrSel == SRC_OSC8) && preWrap));

	// transmit clock from the low count byte
	assign txOvf = tmrTick && (s_r.lowCnt == TMR_TOP);
	// receive copy shares tick and reload
	assign rxOvf = tmrTick && (s_r.rxTmr == TMR_TOP);
	// every second overflow is a bit boundary
	assign txBitTick = txOvf && s_r.txHalf;
	// odd overflows after the start reload fall mid-bit
	assign rxSample = rxOvf && !s_r.rxHalf;

	// bus decode; zero wait states, and a transfer is taken only with hready high
	assign apTake = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
	assign dpWrite = s_r.apValid && s_r.apWrite;
	assign wrCtrl = dpWrite && (s_r.apAddr == ADDR_CTRL);
	assign wrData = dpWrite && (s_r.apAddr == ADDR_DATA);
	assign wrTctrl = dpWrite && (s_r.apAddr == ADDR_TCTRL);
	assign wrReload = dpWrite && (s_r.apAddr == ADDR_RELOAD);
	assign wrLow = dpWrite && (s_r.apAddr == ADDR_LOW);

	// starts are seen only with receive enabled
	assign startDet = s_r.rxEn && (s_r.rxState == RX_IDLE) && rxFall;
	// a write during a frame is dropped; the transmit register is single
	assign txStart = wrData && (s_r.txCnt == 4'h0);
	assign txDoneSet = txBitTick && (s_r.txCnt == 4'h1);
	assign rxLast = s_r.mode ? DATA9_LAST : DATA8_LAST;
	// load gate: buffer free and, when filtering, stop or ninth high
	assign rxGate = !s_r.rxDone && (!s_r.filt || (s_r.mode ? s_r.rxShift[8] : rxLine));
	assign rxLoad = (s_r.rxState == RX_STOP) && rxSample && rxGate;

	always_comb begin
		s_nxt = s_r;

		s_nxt.rxSync = {s_r.rxSync[1:0], pinsIn.serialRxPin};
		s_nxt.oscSync = {s_r.oscSync[1:0], pinsIn.extOscClk};
		s_nxt.extSync = {s_r.extSync[1:0], pinsIn.rateTimerExtInput};

		// prescaler
		if (!s_r.tmrRun || s_r.tmrSel == SRC_SYS || s_r.tmrSel == SRC_EXT) begin
			s_nxt.preCnt = 8'h00;
		end else if (preWrap) begin
			s_nxt.preCnt = 8'h00;
		end else if (preEvt) begin
			s_nxt.preCnt = 8'(s_r.preCnt + 8'h01);
		end

		s_nxt.lowCnt = tmrNext(s_r.lowCnt, s_r.reload, tmrTick);
		// receive timer, private to the receiver
		s_nxt.rxTmr = tmrNext(s_r.rxTmr, s_r.reload, tmrTick);
		if (txOvf) begin
			s_nxt.txHalf = ~s_r.txHalf;
		end
		if (rxOvf) begin
			s_nxt.rxHalf = ~s_r.rxHalf;
		end

		// bus address phase; read data is latched here and stands in the data phase
		s_nxt.apValid = apTake;
		if (apTake) begin
			s_nxt.apWrite = ahbReq.hwrite;
			s_nxt.apAddr = ahbReq.haddr[7:0];
			s_nxt.hrdata = 32'h0000_0000;
			if (!ahbReq.hwrite) begin
				unique case (ahbReq.haddr[7:0])
					ADDR_CTRL: s_nxt.hrdata = {24'h00_0000, s_r.mode, CTRL_BIT6_VAL, s_r.filt,
						s_r.rxEn, s_r.txNinth, s_r.rxNinth, s_r.txDone, s_r.rxDone};
					// reads see the receive buffer only
					ADDR_DATA: s_nxt.hrdata = {24'h00_0000, s_r.rxBuf};
					ADDR_TCTRL: s_nxt.hrdata = {27'h000_0000, s_r.intEn, s_r.tmrSel, s_r.tmrRun};
					ADDR_RELOAD: s_nxt.hrdata = {24'h00_0000, s_r.reload};
					ADDR_LOW: s_nxt.hrdata = {24'h00_0000, s_r.lowCnt};
					default: s_nxt.hrdata = 32'h0000_0000;
				endcase
			end
		end

		// software writes in the data phase
		if (wrCtrl) begin
			s_nxt.mode = ahbReq.hwdata[CTRL_MODE];
			s_nxt.filt = ahbReq.hwdata[CTRL_FILT];
			s_nxt.rxEn = ahbReq.hwdata[CTRL_RXEN];
			s_nxt.txNinth = ahbReq.hwdata[CTRL_TX9];
			s_nxt.rxNinth = ahbReq.hwdata[CTRL_RX9];
			// only this write clears the done flags
			s_nxt.txDone = ahbReq.hwdata[CTRL_TXD];
			s_nxt.rxDone = ahbReq.hwdata[CTRL_RXD];
		end
		if (wrTctrl) begin
			s_nxt.tmrRun = ahbReq.hwdata[TCTRL_RUN];
			s_nxt.tmrSel = ahbReq.hwdata[TCTRL_SEL +: 3];
			s_nxt.intEn = ahbReq.hwdata[TCTRL_IEN];
		end
		if (wrReload) begin
			s_nxt.reload = ahbReq.hwdata[7:0];
		end
		if (wrLow) begin
			s_nxt.lowCnt = ahbReq.hwdata[7:0];
		end

		// transmitter
		if (txStart) begin
			// frame image, start bit at bit 0
			s_nxt.txShift = {1'b1, s_r.mode ? s_r.txNinth : 1'b1, ahbReq.hwdata[7:0], 1'b0};
			s_nxt.txCnt = s_r.mode ? FRAME9_BITS : FRAME8_BITS;
		end else if (txBitTick && s_r.txCnt != 4'h0) begin
			s_nxt.txPin = s_r.txShift[0];
			s_nxt.txShift = {1'b1, s_r.txShift[10:1]};
			s_nxt.txCnt = 4'(s_r.txCnt - 4'h1);
		end
		// set as the stop bit goes out; set wins over a clearing write
		if (txDoneSet) begin
			s_nxt.txDone = 1'b1;
		end

		// receiver
		unique case (s_r.rxState)
			RX_IDLE: begin
				if (startDet) begin
					s_nxt.rxTmr = s_r.reload;
					s_nxt.rxHalf = 1'b0;
					s_nxt.rxState = RX_START;
				end
			end
			RX_START: begin
				// a high line at mid start bit was a glitch
				if (rxSample) begin
					s_nxt.rxState = rxLine ? RX_IDLE : RX_DATA;
					s_nxt.rxCnt = 4'h0;
				end
			end
			RX_DATA: begin
				if (rxSample) begin
					s_nxt.rxShift = {rxLine, s_r.rxShift[8:1]};
					s_nxt.rxCnt = 4'(s_r.rxCnt + 4'h1);
					if (s_r.rxCnt == rxLast) begin
						s_nxt.rxState = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rxSample) begin
					s_nxt.rxState = RX_IDLE;
				end
			end
		endcase

		// a busy buffer refuses the frame, keeping the first byte
		if (rxLoad) begin
			// in 8-bit mode the byte sits in the top of the shifter
			s_nxt.rxBuf = s_r.mode ? s_r.rxShift[7:0] : s_r.rxShift[8:1];
			s_nxt.rxNinth = s_r.mode ? s_r.rxShift[8] : rxLine;
			s_nxt.rxDone = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign serialTxPin = s_r.txPin;
	// level while enabled and a flag is up
	assign serialIrq = s_r.intEn & (s_r.txDone | s_r.rxDone);
	assign ahbRsp.hrdata = s_r.hrdata;
	assign ahbRsp.hreadyout = 1'b1;
	assign ahbRsp.hresp = 1'b0;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	tx_done_time_a: assert property (txDoneSet |=> s_r.txDone && s_r.txPin)
		else $error("transmit done not set with stop bit");

	tx_ninth_load_a: assert property (txStart && s_r.mode |=> s_r.txShift[9] == $past(s_r.txNinth)
		&& s_r.txShift[0] == 1'b0 && s_r.txCnt == FRAME9_BITS)
		else $error("ninth bit frame image wrong");

	tx_frame_len_a: assert property (txStart && !s_r.mode |=> s_r.txCnt == FRAME8_BITS
		&& s_r.txShift[9] == 1'b1)
		else $error("eight bit frame length wrong");

	rx_overrun_keep_a: assert property (s_r.rxDone && !wrCtrl |=> $stable(s_r.rxBuf))
		else $error("receive buffer overwritten while full");

	rx_disabled_idle_a: assert property (!s_r.rxEn && s_r.rxState == RX_IDLE
		|=> s_r.rxState == RX_IDLE)
		else $error("reception started while disabled");

	rx_start_reload_a: assert property (startDet |=> s_r.rxTmr == $past(s_r.reload)
		&& !s_r.rxHalf && s_r.rxState == RX_START)
		else $error("receive timer not reloaded at start");

	tmr_auto_reload_a: assert property (txOvf && !wrLow |=> s_r.lowCnt == $past(s_r.reload))
		else $error("timer overflow did not reload");

	rate_halving_a: assert property (txOvf |=> s_r.txHalf != $past(s_r.txHalf))
		else $error("overflow did not toggle the halving stage");

	rx_filter_gate_a: assert property (s_r.rxState == RX_STOP && rxSample && s_r.filt
		&& s_r.mode && !s_r.rxShift[8] |=> $stable(s_r.rxBuf) && !$rose(s_r.rxDone))
		else $error("filtered frame was loaded");

	flag_kept_a: assert property (s_r.txDone && !wrCtrl |=> s_r.txDone)
		else $error("transmit done cleared without a write");

endmodule

`default_nettype wire

// >>> bench/aspbg_remote_uart.sv
`timescale 1ns/1ps
`default_nettype none

module aspbg_remote_uart (
	// clock
	input wire logic clk,
	// serial link
	input wire logic lineIn,
	output var logic lineOut,
	// frame length and a probe sampled with each bit
	input wire logic frame9,
	input wire logic flag
);
	int bitCycles = 16;
	int frames = 0;
	logic [10:0] rxBits = '0;
	logic [10:0] flagBits = '0;

	initial lineOut = 1'h1;

	// start, data lsb first, ninth in 9-bit frames only, stop
	// samples on the falling clock so the flop outputs have settled
	always @(negedge clk) begin
		if (lineIn === 1'h0) begin
			repeat (bitCycles / 2 - 1) @(negedge clk);
			for (int i = 0; i < (frame9 ? 11 : 10); i++) begin
				rxBits[i] = lineIn;
				flagBits[i] = flag;
				repeat (bitCycles) @(negedge clk);
			end
			frames++;
		end
	end

	// frame sent whole, line rests at mark after
	task automatic sendFrame(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			lineOut <= bits[i];
			repeat (bitCycles) @(posedge clk);
		end
		lineOut <= 1'h1;
	endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import aspbg_pkg::*;
	logic clk = 1'h0;
	logic srst = 1'h1;
	aspbg_ahb_req_t mReq = '0;
	aspbg_ahb_req_t busReq;
	aspbg_ahb_rsp_t rsp;
	aspbg_pins_t pins;
	logic txPin, irq, peerTx;
	logic oscClk = 1'h0;
	logic mode9 = 1'h0;
	logic [7:0] divCnt = 8'h00;
	logic [31:0] rd;
	logic [7:0] d, oldBuf;
	logic m, f, nb;
	logic [2:0] srcTab [6] = '{SRC_SYS, SRC_DIV12, SRC_DIV148, SRC_OSC8, SRC_EXT, SRC_SYS};
	logic [7:0] relTab [6] = '{8'hF8, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hF0};
	int bitTab [6] = '{16, 24, 296, 32, 16, 32};
	int fails = 0;
	int checks = 0;

	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		oscClk <= ~oscClk;
		divCnt <= divCnt + 8'h01;
	end
	// the one slave's hreadyout is the bus hready
	always_comb begin
		busReq = mReq;
		busReq.hready = rsp.hreadyout;
	end
	assign pins = '{serialRxPin: peerTx, extOscClk: oscClk, rateTimerExtInput: divCnt[1]};

	aspbg_serial_port u_dut (.clk(clk), .srst(srst), .ahbReq(busReq), .ahbRsp(rsp),
		.pinsIn(pins), .serialTxPin(txPin), .serialIrq(irq));
	aspbg_remote_uart u_peer (.clk(clk), .lineIn(txPin), .lineOut(peerTx),
		.frame9(mode9), .flag(irq));

	task automatic end_of_test;
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// bounded wait for hready at a rising edge
	task automatic waitReady;
		int n;
		n = 0;
		@(posedge clk);
		while (rsp.hreadyout !== 1'h1) begin
			n++;
			if (n > 100) begin
				fails++;
				end_of_test();
			end
			@(posedge clk);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		mReq.hsel <= 1'h1;
		mReq.htrans <= 2'h2;
		mReq.haddr <= {24'h000000, a};
		mReq.hwrite <= w;
		mReq.hsize <= 3'h2;
		waitReady();
		mReq.hsel <= 1'h0;
		mReq.htrans <= 2'h0;
		mReq.hwdata <= wd;
		waitReady();
		rd = rsp.hrdata;
	endtask

	function automatic logic [10:0] txFrame(input logic [7:0] dat, input logic md, input logic n9);
		return {1'h1, md ? n9 : 1'h1, dat, 1'h0};
	endfunction

	function automatic logic rxLoad(input logic filt, input logic n9);
		return !filt || n9;
	endfunction

	task automatic waitFrame;
		int f0, n;
		f0 = u_peer.frames;
		n = 0;
		while (u_peer.frames == f0) begin
			n++;
			if (n > 5000) begin
				fails++;
				end_of_test();
			end
			@(posedge clk);
		end
	endtask

	// random idle gap so the start edge lands at any timer phase
	task automatic sendRx(input logic [10:0] bits, input logic md);
		repeat ($urandom_range(15, 0)) @(posedge clk);
		u_peer.sendFrame(bits, md ? 11 : 10);
		repeat (4) @(posedge clk);
	endtask

	initial begin
		rd = $urandom(12823);
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		bus(1'h0, ADDR_CTRL, 32'h0);
		check("ctrl reset", 32'h40, rd);
		bus(1'h0, ADDR_DATA, 32'h0);
		check("data reset", 32'h0, rd);
		bus(1'h0, 8'h20, 32'h0);
		check("unmapped", 32'h0, rd);
		check("tx idle", 32'h1, txPin);
		check("hresp okay", 32'h0, rsp.hresp);
		for (int k = 0; k < 6; k++) begin
			u_peer.bitCycles = bitTab[k];
			m = k[0];
			nb = 1'($urandom);
			d = 8'($urandom);
			mode9 <= m;
			bus(1'h1, ADDR_RELOAD, {24'h0, relTab[k]});
			bus(1'h1, ADDR_TCTRL, {27'h0, 1'h1, srcTab[k], 1'h1});
			bus(1'h1, ADDR_CTRL, {24'h0, m, 3'h0, nb, 3'h0});
			bus(1'h1, ADDR_DATA, {24'h0, d});
			waitFrame();
			check("tx frame", txFrame(d, m, nb), m ? u_peer.rxBits : {1'h1, u_peer.rxBits[9:0]});
			check("irq last data", 32'h0, u_peer.flagBits[m ? 9 : 8]);
			check("irq stop", 32'h1, u_peer.flagBits[m ? 10 : 9]);
			bus(1'h0, ADDR_CTRL, 32'h0);
			check("tx done", {m, 3'h4, nb, 3'h2}, rd);
			check("irq held", 32'h1, irq);
			bus(1'h1, ADDR_CTRL, {24'h0, m, 7'h0});
		end
		bus(1'h0, ADDR_DATA, 32'h0);
		check("tx unreadable", 32'h0, rd);
		u_peer.bitCycles = 16;
		bus(1'h1, ADDR_RELOAD, 32'hF8);
		bus(1'h1, ADDR_TCTRL, {28'h1, SRC_SYS, 1'h1});
		oldBuf = 8'h00;
		for (int k = 0; k < 8; k++) begin
			m = k[0];
			f = k[1];
			nb = k[2];
			d = 8'($urandom);
			bus(1'h1, ADDR_CTRL, {24'h0, m, 1'h0, f, 1'h1, 4'h0});
			// address frames carry ninth bit 1; in 9-bit mode the stop bit is the inverse of the ninth bit
			sendRx(m ? {~nb, nb, d, 1'h0} : {1'h1, nb, d, 1'h0}, m);
			bus(1'h0, ADDR_CTRL, 32'h0);
			// a refused frame leaves the ninth bit as the control write just left it
			check("rx ctrl", {m, 1'h1, f, 2'h2, rxLoad(f, nb) ? nb : 1'h0, 1'h0, rxLoad(f, nb)}, rd);
			bus(1'h0, ADDR_DATA, 32'h0);
			check("rx data", rxLoad(f, nb) ? d : oldBuf, rd);
			if (rxLoad(f, nb)) begin
				oldBuf = d;
			end
		end
		bus(1'h1, ADDR_CTRL, 32'h10);
		d = 8'($urandom);
		sendRx({2'h3, d, 1'h0}, 1'h0);
		sendRx({2'h3, ~d, 1'h0}, 1'h0);
		bus(1'h0, ADDR_DATA, 32'h0);
		check("overrun keeps first", d, rd);
		check("irq rx", 32'h1, irq);
		bus(1'h1, ADDR_TCTRL, {28'h0, SRC_SYS, 1'h1});
		// the enable lands at the edge that ends the write, so look one edge later
		@(posedge clk);
		check("irq masked", 32'h0, irq);
		bus(1'h1, ADDR_CTRL, 32'h0);
		sendRx({2'h3, d, 1'h0}, 1'h0);
		bus(1'h0, ADDR_CTRL, 32'h0);
		check("rx disabled", 32'h40, rd);
		end_of_test();
	end
endmodule

`default_nettype wire
